// ===== logic/program_flow_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "pflow_consts.svh"
module program_flow_core
  import pflow_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  output logic      [15:0] imemAddr,
  input  wire logic [15:0] imemData,
  output logic             wdogExpired,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  core_t       st;
  core_t       next_st;
  logic [15:0] ins;
  major_t      op;
  logic [7:0]  fr;
  logic        tick;
  logic        step;
  logic        live;
  logic        useTos;
  logic [4:0]  srcAddr;
  logic [7:0]  ramRdata;
  logic [4:0]  rdAddr;
  logic [7:0]  operand;
  logic [7:0]  mask;
  logic [15:0] nextPc;
  logic [15:0] target;
  logic        flush;
  logic        skip;
  logic        popRet;
  logic        doRam;
  logic [4:0]  ramAddr;
  logic [7:0]  ramVal;
  logic        doWr;
  logic [7:0]  wrVal;

  function automatic logic isSpecial(input logic [7:0] a);
    return a[7:4] == 4'h0;
  endfunction

  function automatic logic [33:0] readReg(input logic [7:0] a, input core_t s);
    if (a == `ADDR_CTRL) begin
      return {`RESP_OKAY, 31'h0, s.run};
    end else if (a == `ADDR_PC) begin
      return {`RESP_OKAY, 16'h0000, s.exPc};
    end else if (a == `ADDR_CORE) begin
      return {`RESP_OKAY, 17'h0, s.speed, 1'b0, s.bank, s.acc};
    end else if (a == `ADDR_LINK) begin
      return {`RESP_OKAY, 16'h0000, s.stack[0]};
    end else if (a == `ADDR_PTRS) begin
      return {`RESP_OKAY, s.dptrH, s.dptrL, s.dspH, s.dspL};
    end else if (a == `ADDR_WDOG) begin
      return {`RESP_OKAY, 19'h0, s.wdogExpired, s.wdog};
    end else begin
      return {`RESP_DECERR, 32'h0000_0000};
    end
  endfunction

  assign imemAddr    = st.pc;
  assign wdogExpired = st.wdogExpired;
  assign awready     = st.awready;
  assign wready      = st.wready;
  assign bresp       = st.bresp;
  assign bvalid      = st.bvalid;
  assign arready     = st.arready;
  assign rdata       = st.rdata;
  assign rresp       = st.rresp;
  assign rvalid      = st.rvalid;

  // ==========================================
  // Data memory, read in decode, written in write stage
  assign rdAddr = (imemData[15:13] == 3'(OP_MOV) && imemData[12:11] == 2'(MV_FROMTOS))
                  ? st.dspL[4:0] : imemData[4:0];

  data_bytes_ram dataRam (
    .mclk   (mclk),
    .sys_rst(sys_rst),
    .en     (step),
    .rdAddr (rdAddr),
    .rdData (ramRdata),
    .wrEn   (st.wbValid),
    .wrAddr (st.wbAddr),
    .wrData (st.wbData)
  );

  // ==========================================
  // Core next state
  always_comb begin
    next_st = st;
    ins     = st.exInstr;
    op      = major_t'(ins[15:13]);
    fr      = ins[7:0];
    tick    = (st.divCnt == 3'h0);
    step    = clkEn && st.run && tick;
    live    = st.exValid && !st.skipPending;
    useTos  = (op == OP_MOV) && (ins[12:11] == 2'(MV_FROMTOS));
    srcAddr = useTos ? st.dspL[4:0] : fr[4:0];
    mask    = 8'h01 << ins[10:8];
    nextPc  = st.exPc + 16'h0001;
    target  = nextPc;
    flush   = 1'b0;
    skip    = 1'b0;
    popRet  = 1'b0;
    doRam   = 1'b0;
    ramAddr = fr[4:0];
    ramVal  = 8'h00;
    doWr    = 1'b0;
    wrVal   = 8'h00;
    // Forward the write stage, the ram has not stored it yet
    if (useTos || !isSpecial(fr)) begin
      operand = (st.wbValid && st.wbAddr == srcAddr) ? st.wbData : ramRdata;
    end else if (fr == `FR_LINKH) begin
      operand = st.stack[0][15:8];
    end else if (fr == `FR_LINKL) begin
      operand = st.stack[0][7:0];
    end else if (fr == `FR_DSPH) begin
      operand = st.dspH;
    end else if (fr == `FR_DSPL) begin
      operand = st.dspL;
    end else if (fr == `FR_STATUS) begin
      operand = {st.bank, 5'h00};
    end else if (fr == `FR_PCL) begin
      operand = nextPc[7:0];
    end else begin
      operand = 8'h00;
    end

    // Speed divider gates every core step
    if (clkEn && st.run) begin
      next_st.divCnt = tick ? st.speed : st.divCnt - 3'h1;
      if (st.wdog == `WDOG_LIMIT) begin
        next_st.wdogExpired = 1'b1;
      end else begin
        next_st.wdog = st.wdog + 12'h001;
      end
    end

    if (step && live) begin
      case (op)
        OP_JMP: begin
          target = {st.bank, ins[12:0]};
          flush  = 1'b1;
        end
        OP_CALL: begin
          for (int i = 15; i > 0; i--) begin
            next_st.stack[i] = st.stack[i - 1];
          end
          next_st.stack[0] = nextPc;
          target = {st.bank, ins[12:0]};
          flush  = 1'b1;
        end
        OP_MISC: begin
          case (misc_t'(ins[10:8]))
            MS_RET: begin
              popRet       = 1'b1;
              next_st.bank = st.stack[0][15:13];
            end
            MS_RETNP: begin
              popRet = 1'b1;
            end
            MS_KICK: begin
              next_st.wdog = 12'h000;
            end
            MS_SPEED: begin
              next_st.speed = ins[2:0];
            end
            MS_PAGE: begin
              next_st.bank = ins[2:0];
            end
            default: begin
              // Codes 6 and 7 are stepping word transfers; the transfer itself is outside
              if (ins[10:9] == 2'h3) begin
                {next_st.dptrH, next_st.dptrL} = {st.dptrH, st.dptrL} + 16'h0002;
              end
            end
          endcase
        end
        OP_RETW: begin
          popRet       = 1'b1;
          next_st.bank = st.stack[0][15:13];
          next_st.acc  = fr;
        end
        OP_BIT: begin
          case (bitop_t'(ins[12:11]))
            BIT_SET: begin
              doWr  = 1'b1;
              wrVal = operand | mask;
            end
            BIT_CLR: begin
              doWr  = 1'b1;
              wrVal = operand & ~mask;
            end
            BIT_SKIPSET: begin
              skip = |(operand & mask);
            end
            default: begin
              skip = ~|(operand & mask);
            end
          endcase
        end
        OP_MOV: begin
          case (move_t'(ins[12:11]))
            MV_TOACC: begin
              next_st.acc = operand;
            end
            MV_FROMACC: begin
              doWr  = 1'b1;
              wrVal = st.acc;
            end
            MV_TOTOS: begin
              doRam   = 1'b1;
              ramAddr = st.dspL[4:0];
              ramVal  = operand;
            end
            default: begin
              doWr  = 1'b1;
              wrVal = operand;
            end
          endcase
        end
        OP_LOAD: begin
          if (ins[12]) begin
            next_st.dptrH = fr;
          end else begin
            next_st.dptrL = fr;
          end
        end
        default: begin
          target = {nextPc[15:8], nextPc[7:0] + st.acc};
          flush  = 1'b1;
        end
      endcase
      if (popRet) begin
        target = st.stack[0];
        flush  = 1'b1;
        for (int i = 0; i < 15; i++) begin
          next_st.stack[i] = st.stack[i + 1];
        end
        next_st.stack[15] = `STACK_RST;
      end
      // Writes to core registers land now, data bytes in the write stage
      if (doWr) begin
        if (!isSpecial(fr)) begin
          doRam   = 1'b1;
          ramAddr = fr[4:0];
          ramVal  = wrVal;
        end else if (fr == `FR_LINKH) begin
          next_st.stack[0][15:8] = wrVal;
        end else if (fr == `FR_LINKL) begin
          next_st.stack[0][7:0] = wrVal;
        end else if (fr == `FR_DSPH) begin
          next_st.dspH = wrVal;
        end else if (fr == `FR_DSPL) begin
          next_st.dspL = wrVal;
        end else if (fr == `FR_STATUS) begin
          next_st.bank = wrVal[`STAT_BANK +: 3];
        end else if (fr == `FR_PCL) begin
          target = {nextPc[15:8], wrVal};
          flush  = 1'b1;
        end
      end
    end

    // ==========================================
    // Pipeline advance
    if (step) begin
      // Slow speeds hold the fetch address so the decoded word stays on the bus
      next_st.pc       = (st.speed == 3'h0) ? st.pc + 16'h0001 : st.pc;
      next_st.decValid = 1'b1;
      next_st.decPc    = st.pc;
      next_st.exValid  = st.decValid;
      next_st.exPc     = st.decPc;
      next_st.exInstr  = imemData;
      next_st.wbValid  = doRam;
      next_st.wbAddr   = ramAddr;
      next_st.wbData   = ramVal;
      if (st.exValid && st.skipPending) begin
        next_st.skipPending = (op == OP_LOAD) ||
          (op == OP_MISC && ins[10:8] == 3'(MS_PAGE));
      end else if (st.exValid) begin
        next_st.skipPending = skip;
      end
      if (flush) begin
        next_st.pc          = target;
        next_st.decValid    = 1'b0;
        next_st.exValid     = 1'b0;
        next_st.skipPending = 1'b0;
      end
    end else if (clkEn && st.run && st.divCnt == 3'h1) begin
      // Last idle cycle before a step: present the word after the decoded one
      if (st.decValid) begin
        next_st.pc = st.decPc + 16'h0001;
      end
    end else if (clkEn && st.decValid) begin
      // Keep the decoded word on the bus; when stopped, drop it and fetch again
      next_st.pc       = st.decPc;
      next_st.decValid = st.run;
    end

    // ==========================================
    // Register bus
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (awvalid && st.awready) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && st.wready) begin
      next_st.wHave = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (next_st.awHave && next_st.wHave && !next_st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.awHave = 1'b0;
      next_st.wHave  = 1'b0;
      next_st.bresp  = readReg(next_st.awAddr, st)[33:32];
      if (next_st.awAddr == `ADDR_CTRL && next_st.wStrb[0]) begin
        next_st.run = next_st.wData[`CTRL_RUN];
      end
    end
    next_st.awready = !next_st.awHave && !next_st.bvalid;
    next_st.wready  = !next_st.wHave && !next_st.bvalid;
    if (st.rvalid && rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
    if (arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      {next_st.rresp, next_st.rdata} = readReg(araddr, st);
    end

    if (sys_rst) begin
      next_st         = '0;
      next_st.stack   = {16{`STACK_RST}};
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || clkEn) begin
      st <= next_st;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  bit_set_a: assert property (step && live && op == OP_BIT && ins[12:11] == 2'h0
    && !isSpecial(fr)
    |=> st.wbValid && st.wbData == ($past(operand) | $past(mask)))
    else $error("bit set result wrong");
  skip_polarity_a: assert property (step && live && op == OP_BIT && ins[12]
    |=> st.skipPending == ($past(ins[11]) ^ $past(|(operand & mask))))
    else $error("skip polarity wrong");
  jump_target_a: assert property (step && live && op == OP_JMP
    |=> st.pc == {$past(st.bank), $past(ins[12:0])} && !st.exValid && !st.decValid)
    else $error("jump target or flush wrong");
  refill_time_a: assert property ((step && live && op == OP_JMP) ##1 step ##1 step
    |=> st.exValid && st.exPc == $past(st.pc, 2))
    else $error("refill not two cycles");
  call_push_a: assert property (step && live && op == OP_CALL
    |=> st.stack[0] == $past(nextPc) && st.stack[15] == $past(st.stack[14]))
    else $error("call push wrong");
  ret_pop_a: assert property (step && live && popRet
    |=> st.pc == $past(st.stack[0]) && st.stack[15] == 16'hFFFF)
    else $error("return pop wrong");
  retnp_keep_a: assert property (step && live && op == OP_MISC && ins[10:8] == 3'h2
    |=> $stable(st.bank))
    else $error("bank changed by retnp");
  retw_acc_a: assert property (step && live && op == OP_RETW
    |=> st.acc == $past(ins[7:0]) && st.bank == $past(st.stack[0][15:13]))
    else $error("retw result wrong");
  wdog_kick_a: assert property (step && live && op == OP_MISC && ins[10:8] == 3'h3
    |=> st.wdog == 12'h000)
    else $error("watchdog not restarted");
  pipe_step_a: assert property (step && st.decValid && !flush
    |=> st.exValid && st.exPc == $past(st.decPc))
    else $error("pipeline did not advance");

  cover property (step && live && op == OP_CALL);
  cover property (step && live && popRet);
  cover property (step && st.exValid && st.skipPending && op == OP_LOAD);
  cover property (step && live && op == OP_ADDPCL);
endmodule
`default_nettype wire

// ===== logic/pflow_consts.svh
`ifndef PFLOW_CONSTS_SVH
`define PFLOW_CONSTS_SVH
// ==========================================
// Register map, byte addresses
`define ADDR_CTRL   8'h00
`define ADDR_PC     8'h04
`define ADDR_CORE   8'h08
`define ADDR_LINK   8'h0C
`define ADDR_PTRS   8'h10
`define ADDR_WDOG   8'h14
// ==========================================
// Field positions and reset values
`define CTRL_RUN    0
`define STAT_BANK   5
`define STACK_RST   16'hFFFF
// ==========================================
// Special data addresses
`define FR_LINKH    8'h02
`define FR_LINKL    8'h03
`define FR_DSPH     8'h06
`define FR_DSPL     8'h07
`define FR_STATUS   8'h08
`define FR_PCL      8'h09
// ==========================================
// Timing and bus answers
`define WDOG_LIMIT  12'hFFF
`define RESP_OKAY   2'h0
`define RESP_DECERR 2'h3
`endif

// ===== logic/pflow_pkg.sv
package pflow_pkg;
  typedef enum logic [2:0] {
    OP_MISC, OP_JMP, OP_CALL, OP_BIT, OP_MOV, OP_RETW, OP_LOAD, OP_ADDPCL
  } major_t;
  typedef enum logic [1:0] {BIT_SET, BIT_CLR, BIT_SKIPSET, BIT_SKIPCLR} bitop_t;
  typedef enum logic [1:0] {MV_TOACC, MV_FROMACC, MV_TOTOS, MV_FROMTOS} move_t;
  typedef enum logic [2:0] {
    MS_NOP, MS_RET, MS_RETNP, MS_KICK, MS_SPEED, MS_PAGE
  } misc_t;

  typedef struct packed {
    logic [15:0]       pc;
    logic              decValid;
    logic [15:0]       decPc;
    logic              exValid;
    logic [15:0]       exPc;
    logic [15:0]       exInstr;
    logic              skipPending;
    logic              wbValid;
    logic [4:0]        wbAddr;
    logic [7:0]        wbData;
    logic [15:0][15:0] stack;
    logic [7:0]        acc;
    logic [2:0]        bank;
    logic [2:0]        speed;
    logic [2:0]        divCnt;
    logic [7:0]        dptrH;
    logic [7:0]        dptrL;
    logic [7:0]        dspH;
    logic [7:0]        dspL;
    logic [11:0]       wdog;
    logic              wdogExpired;
    logic              run;
    logic              awready;
    logic              awHave;
    logic [7:0]        awAddr;
    logic              wready;
    logic              wHave;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } core_t;

  typedef struct packed {
    logic [31:0][7:0] mem;
    logic [7:0]       rdData;
  } ram_t;
endpackage

// ===== logic/data_bytes_ram.sv
`timescale 1ns/1ps
`default_nettype none
module data_bytes_ram
  import pflow_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       en,
  input  wire logic [4:0] rdAddr,
  output logic      [7:0] rdData,
  input  wire logic       wrEn,
  input  wire logic [4:0] wrAddr,
  input  wire logic [7:0] wrData
);
  ram_t st;
  ram_t next_st;

  assign rdData = st.rdData;

  always_comb begin
    next_st = st;
    if (en) begin
      // Write-first so a read racing the write stage sees the new byte
      if (wrEn && wrAddr == rdAddr) begin
        next_st.rdData = wrData;
      end else begin
        next_st.rdData = st.mem[rdAddr];
      end
      if (wrEn) begin
        next_st.mem[wrAddr] = wrData;
      end
    end
    if (sys_rst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end
endmodule
`default_nettype wire

// ===== tb/prog_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Program word store with one-cycle read
module prog_mem_model
(
  input  wire logic        mclk,
  input  wire logic        clkEn,
  input  wire logic [15:0] imemAddr,
  output logic      [15:0] imemData,
  input  wire logic        loadEn,
  input  wire logic [15:0] loadAddr,
  input  wire logic [15:0] loadData
);
  logic [15:0] mem [65536];

  // Unwritten words read as no-operation
  initial begin
    imemData = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // Word held while frozen, the core relies on it
  always @(posedge mclk) begin
    if (loadEn) mem[loadAddr] <= loadData;
    if (clkEn) imemData <= mem[imemAddr];
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pflow_consts.svh"
module tb
  import pflow_pkg::*;
;
  logic        mclk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        clkEn = 1'h1;
  logic        gate = 1'h0;
  logic [15:0] imemAddr;
  logic [15:0] imemData;
  logic        wdogExpired;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'h0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        wvalid = 1'h0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'h0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'h0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'h0;
  logic        loadEn = 1'h0;
  logic [15:0] loadAddr = 16'h0;
  logic [15:0] loadData = 16'h0;
  logic [31:0] core, link, ptrs, wdg, rd;
  logic [1:0]  rr;
  logic [7:0]  val;
  int          b, k;
  int          errTotal = 0;
  int          testsRun = 0;

  program_flow_core u_program_flow_core (
    .mclk, .sys_rst, .clkEn, .imemAddr, .imemData, .wdogExpired,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready
  );
  prog_mem_model u_prog_mem_model (
    .mclk, .clkEn, .imemAddr, .imemData, .loadEn, .loadAddr, .loadData
  );

  always #4 mclk = ~mclk;
  // Random stalls only from the write that starts the core to the write that stops it
  always @(posedge mclk) clkEn <= gate ? ($urandom % 8 != 0) : 1'h1;

  // ==========================================
  // Helpers
  function automatic logic [12:0] bo(bitop_t o, int n);
    return {o, n[2:0], 8'h10};
  endfunction
  function automatic logic [12:0] ms(misc_t s, logic [2:0] v);
    return {2'h0, s, 5'h0, v};
  endfunction
  function automatic logic [7:0] bitres(logic [7:0] r, int n, bit clr);
    return clr ? r & ~(8'h1 << n) : r | (8'h1 << n);
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      errTotal++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic endSim;
    $display("Mismatches %0d of %0d checks", errTotal, testsRun);
    if (errTotal == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // A frozen edge moves nothing, so only enabled edges count as handshakes
    do begin
      @(posedge mclk);
      if (awready && clkEn) awvalid <= 1'h0;
      if (wready && clkEn) wvalid <= 1'h0;
    end while (!(bvalid === 1'h1 && clkEn));
    rr = bresp;
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (arready && clkEn) arvalid <= 1'h0;
    end while (!(rvalid === 1'h1 && clkEn));
    d = rdata;
    rr = rresp;
    rready <= 1'h0;
  endtask
  task automatic put(input logic [15:0] a, input logic [2:0] m, input logic [12:0] x);
    @(posedge mclk);
    loadEn <= 1'h1;
    loadAddr <= a;
    loadData <= {m, x};
  endtask
  // Fresh reset per program, so stack and bank start known
  task automatic run(input int n);
    @(posedge mclk);
    loadEn <= 1'h0;
    sys_rst <= 1'h1;
    @(posedge mclk);
    sys_rst <= 1'h0;
    gate <= 1'h1;
    axw(`ADDR_CTRL, 32'h1);
    repeat (n) @(posedge mclk);
    axw(`ADDR_CTRL, 32'h0);
    gate <= 1'h0;
    axr(`ADDR_CORE, core);
    axr(`ADDR_LINK, link);
    axr(`ADDR_PTRS, ptrs);
    axr(`ADDR_WDOG, wdg);
  endtask

  // ==========================================
  // Watchdog
  initial begin
    #400000;
    errTotal++;
    endSim();
  end

  // ==========================================
  // Tests
  initial begin
    void'($urandom(64));
    repeat (8) @(posedge mclk);
    sys_rst <= 1'h0;
    axr(`ADDR_CTRL, rd);
    chk("run", 32'h0, rd);
    axr(`ADDR_LINK, rd);
    chk("link", 32'hFFFF, rd);
    axw(`ADDR_LINK, 32'h1234);
    axr(`ADDR_LINK, rd);
    chk("link ro", 32'hFFFF, rd);
    axr(8'h18, rd);
    chk("rd resp", `RESP_DECERR, rr);
    chk("rd data", 32'h0, rd);
    axw(8'h18, 32'h5);
    chk("wr resp", `RESP_DECERR, rr);
    for (int p = 0; p < 2; p++) begin
      val = 8'($urandom);
      b = $urandom % 8;
      put(16'h0, OP_JMP, 13'h20);
      put(16'h20, OP_CALL, 13'h30);
      put(16'h21, OP_MOV, {MV_FROMACC, 11'h10});
      put(16'h22, OP_BIT, bo(p ? BIT_CLR : BIT_SET, b));
      put(16'h23, OP_MOV, {MV_TOACC, 11'h10});
      put(16'h24, OP_LOAD, 13'h1012);
      put(16'h25, OP_LOAD, 13'h0034);
      put(16'h26, OP_BIT, bo(p ? BIT_SKIPCLR : BIT_SKIPSET, b));
      // Loads, page and jump below all fall in the extended skip
      put(16'h27, OP_LOAD, 13'h10AA);
      put(16'h28, OP_LOAD, 13'h0055);
      put(16'h29, OP_MISC, ms(MS_PAGE, 3'h1));
      put(16'h2A, OP_JMP, 13'h1FFF);
      put(16'h2B, OP_BIT, bo(p ? BIT_SKIPSET : BIT_SKIPCLR, b));
      put(16'h2C, OP_MISC, ms(MS_PAGE, 3'h3));
      put(16'h2D, OP_JMP, 13'h2D);
      put(16'h602D, OP_JMP, 13'h2D);
      put(16'h30, OP_RETW, {5'h0, val});
      run(300);
      chk("acc", bitres(val, b, p[0]), core[7:0]);
      chk("bank", 32'h3, core[10:8]);
      chk("dptr", 32'h1234, ptrs[31:16]);
      chk("link", 32'hFFFF, link);
    end
    for (int p = 0; p < 2; p++) begin
      put(16'h0, OP_JMP, 13'h40);
      put(16'h40, OP_CALL, 13'h50);
      put(16'h50, OP_RETW, 13'hE0);
      put(16'h41, OP_CALL, 13'h52);
      put(16'h52, OP_MOV, {MV_FROMACC, 11'h02});
      put(16'h53, OP_MISC, ms(p ? MS_RETNP : MS_RET, 3'h0));
      put(16'h42, OP_JMP, 13'h42);
      put(16'hE042, OP_JMP, 13'h42);
      run(300);
      chk("bank", p ? 32'h0 : 32'h7, core[10:8]);
      chk("acc", 32'hE0, core[7:0]);
    end
    put(16'h0, OP_CALL, 13'h1E1);
    put(16'h1E1, OP_JMP, 13'h1E1);
    run(100);
    chk("link", 32'h1, link);
    put(16'h0, OP_JMP, 13'h90);
    for (int i = 0; i < 17; i++) begin
      put(16'('h90 + 2 * i), OP_CALL, 13'('h92 + 2 * i));
      put(16'('h91 + 2 * i), OP_MISC, ms(MS_RET, 3'h0));
    end
    put(16'hB2, OP_MISC, ms(MS_RET, 3'h0));
    put(16'h91, OP_JMP, 13'h91);
    put(16'hFFFF, OP_JMP, 13'h1FF0);
    put(16'hFFF0, OP_JMP, 13'h1FF0);
    run(6000);
    chk("bank", 32'h7, core[10:8]);
    chk("link", 32'hFFFF, link);
    chk("expired", 32'h1, wdg[12]);
    chk("flag", 32'h1, wdogExpired);
    k = 1 + $urandom % 5;
    put(16'h0, OP_JMP, 13'hC0);
    put(16'hC0, OP_CALL, 13'hD0);
    put(16'hD0, OP_RETW, 13'(k));
    put(16'hC1, OP_ADDPCL, 13'h0);
    for (int i = 'hC2; i < 'hC8; i++) put(16'(i), OP_MISC, ms(MS_PAGE, 3'h1));
    put(16'('hC2 + k), OP_JMP, 13'('hC2 + k));
    run(300);
    chk("bank", 32'h0, core[10:8]);
    // Data stack round trip, then two stepping word transfers
    val = 8'($urandom) | 8'h01;
    put(16'h0, OP_CALL, 13'h8);
    put(16'h8, OP_RETW, {5'h0, val});
    put(16'h1, OP_MOV, {MV_FROMACC, 11'h07});
    put(16'h2, OP_MOV, {MV_TOTOS, 11'h07});
    put(16'h3, OP_MOV, {MV_FROMTOS, 11'h06});
    put(16'h4, OP_MISC, ms(misc_t'(3'h6), 3'h0));
    put(16'h5, OP_MISC, ms(misc_t'(3'h7), 3'h0));
    put(16'h6, OP_JMP, 13'h6);
    run(100);
    chk("dstack", {16'h0, val, val}, ptrs[15:0]);
    chk("step ptr", 32'h4, ptrs[31:16]);
    val = 8'($urandom % 8);
    put(16'h0, OP_JMP, 13'hE0);
    put(16'hE0, OP_MISC, ms(MS_SPEED, val[2:0]));
    put(16'hE1, OP_MISC, ms(MS_KICK, 3'h0));
    put(16'hE2, OP_JMP, 13'hE1);
    run(6000);
    chk("speed", {24'h0, val}, core[14:12]);
    chk("expired", 32'h0, wdg[12]);
    endSim();
  end
endmodule
`default_nettype wire
